/* File: hdl/sampling_pll_divider_config.sv */
// configuration registers of the sampling-clock synthesiser with serial control port
// Notes on behaviour
// - the reference clock output is on only while its enable bit and the synth enable are both set.
// - the reference output enable bit comes out of reset as one so the output runs unconfigured.
// - the second divider codes 0,1,2 divide by 1,2,4, code 3 is reserved, its output is sampling.
// - the first divider codes 0,1,2 divide by 5,4,3, code 3 is reserved, it feeds the second.
// - the third divider field is six bits, equals the ratio directly and resets to 32.
// - the third divider divides the sampling clock into the loop feedback clock.
// - one four-bit pre-emphasis value applies to every serial lane together.
`timescale 1ns/1ns
module sampling_pll_divider_config (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // serial control port pins
  input  wire logic        sclk_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_n_out,
  // synthesiser controls from pins
  input  wire logic        synth_enable_in,
  input  wire logic        synth_loop_reset_in,
  // oscillator edge enable, same clock domain
  input  wire logic        vco_tick_in,
  // clock outputs as enables
  output logic             reference_clock_output,
  output logic             sampling_tick_out,
  output logic             feedback_tick_out,
  // analogue settings
  output logic [6:0]       oscillator_bias_level_out,
  output logic [3:0]       lane_pre_emphasis_out
);

  //////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [2:0]  sclk_sync;
    logic [1:0]  cs_sync;
    logic [1:0]  sdi_sync;
    logic [1:0]  enable_sync;
    logic [1:0]  loop_reset_sync;
    logic [4:0]  bit_count;
    logic [22:0] shift_in;
    logic [7:0]  shift_out;
    logic        sdo_off;
    logic [7:0]  ref_ctrl;
    logic [7:0]  fbdiv_vp;
    logic [7:0]  fbdiv_n;
    logic [7:0]  osc_bias;
    logic [7:0]  lane_pe;
    logic        ref_clk_on;
  } cfg_state_t;

  localparam cfg_state_t STATE_RESET = '{
    sclk_sync:       3'h0,
    cs_sync:         2'h3,
    sdi_sync:        2'h0,
    enable_sync:     2'h0,
    loop_reset_sync: 2'h3,
    bit_count:       5'h00,
    shift_in:        23'h000000,
    shift_out:       8'h00,
    sdo_off:         1'b1,
    ref_ctrl:        synth_cfg_pkg::RST_REF_CTRL,
    fbdiv_vp:        synth_cfg_pkg::RST_FBDIV_VP,
    fbdiv_n:         synth_cfg_pkg::RST_FBDIV_N,
    osc_bias:        synth_cfg_pkg::RST_OSC_BIAS,
    lane_pe:         synth_cfg_pkg::RST_LANE_PE,
    ref_clk_on:      1'b0
  };

  cfg_state_t state;
  cfg_state_t next_state;

  div_if v_stage ();
  div_if p_stage ();
  div_if n_stage ();

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] read_mux(input logic [14:0] addr, input cfg_state_t s);
    logic [7:0] data;
    data = synth_cfg_pkg::UNMAPPED_DATA;
    case (addr)
      synth_cfg_pkg::ADDR_REF_CTRL: data = s.ref_ctrl;
      synth_cfg_pkg::ADDR_FBDIV_VP: data = s.fbdiv_vp;
      synth_cfg_pkg::ADDR_FBDIV_N:  data = s.fbdiv_n;
      synth_cfg_pkg::ADDR_OSC_BIAS: data = s.osc_bias;
      synth_cfg_pkg::ADDR_LANE_PE:  data = s.lane_pe;
      default:                      data = synth_cfg_pkg::UNMAPPED_DATA;
    endcase
    return data;
  endfunction

  function automatic logic [5:0] v_ratio(input logic [1:0] code);
    logic [5:0] r;
    case (code)
      synth_cfg_pkg::CODE_0: r = synth_cfg_pkg::V_RATIO_0;
      synth_cfg_pkg::CODE_1: r = synth_cfg_pkg::V_RATIO_1;
      synth_cfg_pkg::CODE_2: r = synth_cfg_pkg::V_RATIO_2;
      default:               r = synth_cfg_pkg::RATIO_STOP;
    endcase
    return r;
  endfunction

  function automatic logic [5:0] p_ratio(input logic [1:0] code);
    logic [5:0] r;
    case (code)
      synth_cfg_pkg::CODE_0: r = synth_cfg_pkg::P_RATIO_0;
      synth_cfg_pkg::CODE_1: r = synth_cfg_pkg::P_RATIO_1;
      synth_cfg_pkg::CODE_2: r = synth_cfg_pkg::P_RATIO_2;
      default:               r = synth_cfg_pkg::RATIO_STOP;
    endcase
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // serial port and register file
  logic        sclk_rise;
  logic        sclk_fall;
  logic        selected;
  logic [23:0] frame;

  always_comb begin
    next_state = state;
    next_state.sclk_sync       = {state.sclk_sync[1:0], sclk_in};
    next_state.cs_sync         = {state.cs_sync[0], chip_select_n_in};
    next_state.sdi_sync        = {state.sdi_sync[0], sdi_in};
    next_state.enable_sync     = {state.enable_sync[0], synth_enable_in};
    next_state.loop_reset_sync = {state.loop_reset_sync[0], synth_loop_reset_in};

    sclk_rise = state.sclk_sync[1] & ~state.sclk_sync[2];
    sclk_fall = ~state.sclk_sync[1] & state.sclk_sync[2];
    selected  = ~state.cs_sync[1];
    frame     = {state.shift_in, state.sdi_sync[1]};

    if (!selected) begin
      // a frame cut short by chip select is dropped, nothing is written
      next_state.bit_count = 5'h00;
      next_state.sdo_off   = 1'b1;
    end else begin
      if (sclk_rise && state.bit_count <= synth_cfg_pkg::LAST_DATA_BIT) begin
        next_state.shift_in  = frame[22:0];
        next_state.bit_count = state.bit_count + 5'h01;
        if (state.bit_count == synth_cfg_pkg::LAST_ADDR_BIT && frame[15]) begin
          next_state.shift_out = read_mux(frame[14:0], state);
          next_state.sdo_off   = 1'b0;
        end
        if (state.bit_count == synth_cfg_pkg::LAST_DATA_BIT && !frame[23]) begin
          // reserved bits are stored as written; keeping them default is the host's job
          case (frame[22:8])
            synth_cfg_pkg::ADDR_REF_CTRL: next_state.ref_ctrl = frame[7:0];
            synth_cfg_pkg::ADDR_FBDIV_VP: next_state.fbdiv_vp = frame[7:0];
            synth_cfg_pkg::ADDR_FBDIV_N:  next_state.fbdiv_n  = frame[7:0];
            synth_cfg_pkg::ADDR_OSC_BIAS: next_state.osc_bias = frame[7:0];
            synth_cfg_pkg::ADDR_LANE_PE:  next_state.lane_pe  = frame[7:0];
            default: ;
          endcase
        end
      end
      // the bit after the load is still being sampled, so shifting starts one edge later
      if (sclk_fall && !state.sdo_off
          && state.bit_count > synth_cfg_pkg::LAST_ADDR_BIT + 5'h01) begin
        next_state.shift_out = {state.shift_out[6:0], 1'b0};
      end
    end

    next_state.ref_clk_on = state.ref_ctrl[synth_cfg_pkg::REF_EN_BIT]
                            & state.enable_sync[1];
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // feedback divider chain: oscillator -> first -> second (sampling) -> third (feedback)
  assign v_stage.tick_in = vco_tick_in;
  assign v_stage.ratio   = v_ratio(state.fbdiv_vp[synth_cfg_pkg::V_DIV_LSB +: 2]);
  assign v_stage.hold    = state.loop_reset_sync[1];
  assign p_stage.tick_in = v_stage.tick_out;
  assign p_stage.ratio   = p_ratio(state.fbdiv_vp[synth_cfg_pkg::P_DIV_LSB +: 2]);
  assign p_stage.hold    = state.loop_reset_sync[1];
  assign n_stage.tick_in = p_stage.tick_out;
  assign n_stage.ratio   = state.fbdiv_n[synth_cfg_pkg::N_DIV_LSB +: 6];
  assign n_stage.hold    = state.loop_reset_sync[1];

  // all stages share the loop reset, so no stage is left mid-count after a ratio change made under loop reset
  feedback_divider first_div (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .stage    (v_stage)
  );

  feedback_divider second_div (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .stage    (p_stage)
  );

  feedback_divider third_div (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .stage    (n_stage)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sdo enable is kept inverted in its own flop so the pin needs no gate after it
  assign sdo_out                   = state.shift_out[7];
  assign sdo_oe_n_out              = state.sdo_off;
  assign reference_clock_output    = state.ref_clk_on;
  assign sampling_tick_out         = p_stage.tick_out;
  assign feedback_tick_out         = n_stage.tick_out;
  assign oscillator_bias_level_out = state.osc_bias[synth_cfg_pkg::BIAS_LSB +: 7];
  assign lane_pre_emphasis_out     = state.lane_pe[synth_cfg_pkg::PE_LSB +: 4];

endmodule

/* File: hdl/synth_cfg_pkg.sv */
// constants for the sampling-clock synthesiser configuration block
package synth_cfg_pkg;

  // serial control port framing: rw bit, address, data, msb first
  localparam int          ADDR_W     = 15;
  localparam int          DATA_W     = 8;
  localparam int          FRAME_BITS = 24;
  localparam int          ADDR_BITS  = 16;
  localparam logic [4:0]  LAST_ADDR_BIT = 5'h0F;
  localparam logic [4:0]  LAST_DATA_BIT = 5'h17;

  // register offsets
  localparam logic [14:0] ADDR_REF_CTRL = 15'h003C;
  localparam logic [14:0] ADDR_FBDIV_VP = 15'h003D;
  localparam logic [14:0] ADDR_FBDIV_N  = 15'h003E;
  localparam logic [14:0] ADDR_OSC_BIAS = 15'h003F;
  localparam logic [14:0] ADDR_LANE_PE  = 15'h0048;

  // reset values
  localparam logic [7:0]  RST_REF_CTRL = 8'h01;
  localparam logic [7:0]  RST_FBDIV_VP = 8'h00;
  localparam logic [7:0]  RST_FBDIV_N  = 8'h20;
  localparam logic [7:0]  RST_OSC_BIAS = 8'h4F;
  localparam logic [7:0]  RST_LANE_PE  = 8'h00;
  localparam logic [7:0]  UNMAPPED_DATA = 8'h00;

  // field positions
  localparam int REF_EN_BIT = 0;
  localparam int V_DIV_LSB  = 0;
  localparam int P_DIV_LSB  = 2;
  localparam int N_DIV_LSB  = 0;
  localparam int BIAS_LSB   = 0;
  localparam int PE_LSB     = 0;
  localparam int CODE_W     = 2;
  localparam int RATIO_W    = 6;
  localparam int BIAS_W     = 7;
  localparam int PE_W       = 4;

  // divider codes and the ratios they select; 0 means stopped
  localparam logic [1:0] CODE_0 = 2'h0;
  localparam logic [1:0] CODE_1 = 2'h1;
  localparam logic [1:0] CODE_2 = 2'h2;
  localparam logic [5:0] V_RATIO_0 = 6'h05;
  localparam logic [5:0] V_RATIO_1 = 6'h04;
  localparam logic [5:0] V_RATIO_2 = 6'h03;
  localparam logic [5:0] P_RATIO_0 = 6'h01;
  localparam logic [5:0] P_RATIO_1 = 6'h02;
  localparam logic [5:0] P_RATIO_2 = 6'h04;
  localparam logic [5:0] RATIO_STOP = 6'h00;

endpackage

/* File: hdl/div_if.sv */
// carrier between the configuration logic and one feedback divider stage
`timescale 1ns/1ns
interface div_if;
  logic                                tick_in;
  logic [synth_cfg_pkg::RATIO_W-1:0]   ratio;
  logic                                hold;
  logic                                tick_out;

  modport divider (input tick_in, input ratio, input hold, output tick_out);
  modport control (output tick_in, output ratio, output hold, input tick_out);
endinterface

/* File: hdl/feedback_divider.sv */
// one integer divider stage working on single-cycle tick enables
`timescale 1ns/1ns
module feedback_divider (
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   reset_in,
  // stage connection
  div_if.divider      stage
);

  typedef struct packed {
    logic [synth_cfg_pkg::RATIO_W-1:0] count;
    logic                              tick;
  } div_state_t;

  div_state_t state;
  div_state_t next_state;

  always_comb begin
    next_state      = state;
    next_state.tick = 1'b0;
    // a stopped ratio (reserved code or zero) gives no output at all
    if (stage.hold || stage.ratio == synth_cfg_pkg::RATIO_STOP) begin
      next_state.count = '0;
    end else if (stage.tick_in) begin
      if (state.count == stage.ratio - 6'h01) begin
        next_state.count = '0;
        next_state.tick  = 1'b1;
      end else begin
        next_state.count = state.count + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign stage.tick_out = state.tick;

endmodule

/* File: testbench/sampling_pll_divider_config_checker.sv */
// port assertions for the synthesiser configuration block
`timescale 1ns/1ns
module sampling_pll_divider_config_checker (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       reset_in,
  // serial port
  input wire logic       sclk_in,
  input wire logic       chip_select_n_in,
  input wire logic       sdi_in,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_n_out,
  // synth pins and outputs
  input wire logic       synth_enable_in,
  input wire logic       synth_loop_reset_in,
  input wire logic       vco_tick_in,
  input wire logic       reference_clock_output,
  input wire logic       sampling_tick_out,
  input wire logic       feedback_tick_out,
  input wire logic [6:0] oscillator_bias_level_out,
  input wire logic [3:0] lane_pre_emphasis_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  // pin enable passes a 2-flop sync, so five low samples are enough
  property p_ref_off; (!synth_enable_in)[*5] |-> !reference_clock_output; endproperty
  property p_tick_stop; synth_loop_reset_in[*5] |-> !sampling_tick_out && !feedback_tick_out;
  endproperty
  property p_samp_src; sampling_tick_out |-> $past(vco_tick_in, 2); endproperty
  property p_fb_src; feedback_tick_out |-> $past(sampling_tick_out); endproperty
  // shortest first-stage ratio is three
  property p_samp_gap; sampling_tick_out |=> !sampling_tick_out [*2]; endproperty
  property p_oe_idle; chip_select_n_in[*6] |-> sdo_oe_n_out; endproperty
  property p_set_hold; chip_select_n_in[*8] |->
    $stable(lane_pre_emphasis_out) && $stable(oscillator_bias_level_out); endproperty
  property p_rst_vals; $fell(reset_in) |->
    oscillator_bias_level_out == 7'h4F && lane_pre_emphasis_out == 4'h0 && sdo_oe_n_out;
  endproperty
  a_ref_off: assert property (p_ref_off) else $error("ref output on while disabled");
  a_tick_stop: assert property (p_tick_stop) else $error("tick during loop reset");
  a_samp_src: assert property (p_samp_src) else $error("sampling tick without input");
  a_fb_src: assert property (p_fb_src) else $error("feedback tick without sampling");
  a_samp_gap: assert property (p_samp_gap) else $error("sampling ticks too close");
  a_oe_idle: assert property (p_oe_idle) else $error("sdo driven outside frame");
  a_set_hold: assert property (p_set_hold) else $error("setting moved without frame");
  a_rst_vals: assert property (p_rst_vals) else $error("bad value out of reset");
  c_fb: cover property (feedback_tick_out);
  c_read: cover property (!sdo_oe_n_out);
  c_ref: cover property (reference_clock_output);
endmodule
bind sampling_pll_divider_config sampling_pll_divider_config_checker chk (
  .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk_in), .chip_select_n_in(chip_select_n_in),
  .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_n_out(sdo_oe_n_out),
  .synth_enable_in(synth_enable_in), .synth_loop_reset_in(synth_loop_reset_in),
  .vco_tick_in(vco_tick_in), .reference_clock_output(reference_clock_output),
  .sampling_tick_out(sampling_tick_out), .feedback_tick_out(feedback_tick_out),
  .oscillator_bias_level_out(oscillator_bias_level_out),
  .lane_pre_emphasis_out(lane_pre_emphasis_out));

/* File: testbench/serial_host.sv */
// host controller model that runs serial control port frames
`timescale 1ns/1ns
module serial_host (
  // clock
  input  wire logic clk_in,
  // serial port
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in
);
  initial begin
    sclk_out <= 1'b0;
    cs_n_out <= 1'b1;
    sdi_out <= 1'b0;
  end
  ////////////////////////////////////////
  // half periods of five clocks keep clear of the sync delay
  task automatic xfer(input logic rw, input logic [14:0] a, input logic [7:0] wd,
                      output logic [7:0] rdata);
    logic [23:0] fr;
    fr = {rw, a, wd};
    rdata = 8'h00;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_out <= fr[i];
      repeat (5) @(posedge clk_in);
      sclk_out <= 1'b1;
      if (i < 8) rdata[i] = (sdo_oe_n_in === 1'b0) ? sdo_in : 1'bx;
      repeat (5) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
    repeat (5) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // a released line must not keep showing the last bit
    sdi_out <= ~sdi_out;
    repeat (6) @(posedge clk_in);
  endtask
endmodule

/* File: testbench/sampling_pll_divider_config_tb.sv */
// self-checking bench for the synthesiser configuration block
`timescale 1ns/1ns
module sampling_pll_divider_config_tb;
  logic       clk_in, reset_in, sclk, cs_n, sdi, sdo, oe_n, en, lrst, vco, ref_o, samp, fb, slow;
  logic [6:0] bias;
  logic [3:0] pe;
  logic [7:0] rd;
  int         n_errors, checked, sc, fc, sp, fp, ns;
  logic [14:0] adr [5] = '{15'h003C, 15'h003D, 15'h003E, 15'h003F, 15'h0048};
  logic [7:0]  rst [5] = '{8'h01, 8'h00, 8'h20, 8'h4F, 8'h00};
  logic [7:0]  val [5] = '{8'h00, 8'h09, 8'h3F, 8'h4A, 8'h0A};
  int          vr [3]  = '{5, 4, 3};
  int          pr [3]  = '{1, 2, 4};
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  sampling_pll_divider_config dut (
    .clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .chip_select_n_in(cs_n),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(oe_n), .synth_enable_in(en),
    .synth_loop_reset_in(lrst), .vco_tick_in(vco), .reference_clock_output(ref_o),
    .sampling_tick_out(samp), .feedback_tick_out(fb), .oscillator_bias_level_out(bias),
    .lane_pre_emphasis_out(pe));
  serial_host host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_n_in(oe_n));
  ////////////////////////////////////////
  // oscillator edges every cycle, or every other one when slow
  // tick periods in clocks, and a running count of sampling ticks
  always @(posedge clk_in) begin
    vco <= slow ? ~vco : 1'b1;
    sc <= samp ? 1 : sc + 1;
    fc <= fb ? 1 : fc + 1;
    if (samp) sp <= sc;
    if (fb) fp <= fc;
    ns <= ns + samp;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [14:0] a, input logic [7:0] exp);
    host.xfer(1'b1, a, 8'h00, rd);
    check(rd, exp);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_in);
    n_errors++;
    stop_test();
  end
  initial begin
    reset_in <= 1'b1;
    en <= 1'b1;
    lrst <= 1'b0;
    slow <= 1'b0;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({7'h00, ref_o}, 8'h01);
    check({1'b0, bias}, 8'h4F);
    for (int i = 0; i < 5; i++) rchk(adr[i], rst[i]);
    host.xfer(1'b0, 15'h0040, 8'hFF, rd);
    rchk(15'h0040, 8'h00);
    lrst <= 1'b1;
    for (int i = 0; i < 5; i++) host.xfer(1'b0, adr[i], val[i], rd);
    for (int i = 0; i < 5; i++) rchk(adr[i], val[i]);
    check({1'b0, bias}, 8'h4A);
    check({4'h0, pe}, 8'h0A);
    check({7'h00, ref_o}, 8'h00);
    host.xfer(1'b0, 15'h003C, 8'h01, rd);
    en <= 1'b0;
    repeat (6) @(posedge clk_in);
    check({7'h00, ref_o}, 8'h00);
    en <= 1'b1;
    repeat (6) @(posedge clk_in);
    check({7'h00, ref_o}, 8'h01);
    // codes 0..2 of each stage, a reserved code in each stage, then half-rate oscillator edges
    for (int i = 0; i < 6; i++) begin
      int v, p, s0, k;
      v = (i == 4) ? 3 : i % 3;
      p = (i == 3) ? 3 : i % 3;
      k = (i == 5) ? 2 : 1;
      lrst <= 1'b1;
      slow <= (i == 5);
      repeat (4) @(posedge clk_in);
      host.xfer(1'b0, 15'h003D, {4'h0, p[1:0], v[1:0]}, rd);
      host.xfer(1'b0, 15'h003E, 8'(i + 1), rd);
      lrst <= 1'b0;
      s0 = ns;
      repeat (400) @(posedge clk_in);
      if (i < 3 || i == 5) begin
        check(8'(sp), 8'(k * vr[v] * pr[p]));
        check(8'(fp), 8'(k * vr[v] * pr[p] * (i + 1)));
      end else begin
        check(8'(ns - s0), 8'h00);
      end
    end
    stop_test();
  end
endmodule
